// >>> shared/mtc_defines.svh
// Purpose: Offsets, field positions, reset values and encodings of the translation config block
// Assumes: Big-endian bit n of a control word sits at vector index 31-n
// Notes:   Definitions only
`ifndef MTC_DEFINES_SVH
`define MTC_DEFINES_SVH

// ----------------------------------------------------------------------
// Special-register selects
// ----------------------------------------------------------------------
`define MTC_SEL_ICTRL   2'h0
`define MTC_SEL_IAP     2'h1
`define MTC_SEL_DCTRL   2'h2

// ----------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------
`define MTC_B_GPM       31
`define MTC_B_PPM       30
`define MTC_B_INHIBIT_DEFAULT     29
`define MTC_B_WRITETHROUGH_DEFAULT     28
`define MTC_B_KEEP      27
`define MTC_B_WALK_ASSIST_MODE      26
`define MTC_B_PRIV_COMPARE_MODE      25
`define MTC_PTR_MSB     12
`define MTC_PTR_LSB     8

// ----------------------------------------------------------------------
// Implemented-bit masks and reset values
// ----------------------------------------------------------------------
`define MTC_ICTRL_MASK  32'hea001f00
`define MTC_DCTRL_MASK  32'hfe001f00
`define MTC_CTRL_RESET  32'h00000000

// ----------------------------------------------------------------------
// Pointer wrap values and protection encodings
// ----------------------------------------------------------------------
`define MTC_WRAP_FULL   5'h07
`define MTC_WRAP_KEEP   5'h05
`define MTC_PP_PRIV     4'h8
`define MTC_PP_PROB     4'h4
`define MTC_PP_BOTH     4'hc
`define MTC_GP_00       2'h0
`define MTC_GP_01       2'h1
`define MTC_GP_10       2'h2
`define MTC_GP_11       2'h3

`endif

// >>> shared/mtc_pkg.sv
// Purpose: Types shared by the translation config block
// Assumes: Page number is effective address bits 31:12
// Notes:   No constants here, see mtc_defines.svh
`default_nettype none
package mtc_pkg;

    typedef struct packed {
        logic [19:0] epn;
        logic [3:0]  space_tag;
        logic [3:0]  entry_group_select;
        logic [3:0]  pp;
        logic        small_page_size;
        logic        common_space_page;
        logic        cache_inhibit_attr;
        logic        valid;
    } mtc_entry_t;

    typedef struct packed {
        logic        valid;
        logic [21:0] page_sub;
        logic        priv;
    } mtc_req_t;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic        ci;
        logic [3:0]  grp;
        logic [3:0]  pp;
        logic        priv;
    } mtc_rsp_t;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic        allow;
        logic        ci;
        logic        wt;
    } mtc_res_t;

endpackage : mtc_pkg
`default_nettype wire

// >>> logic/mtc_xlate.sv
// Purpose: Entry store and match for one translation side
// Assumes: Loads, invalidations and lookups arrive on mclk_i
// Notes:   Response is registered, one cycle after the request
`include "mtc_defines.svh"
`default_nettype none
module mtc_xlate #(
    parameter int ENTRIES = 8
) (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_i,
    input  wire logic                 load_i,
    input  wire logic [4:0]           load_idx_i,
    input  wire mtc_pkg::mtc_entry_t  load_entry_i,
    input  wire logic                 inval_one_i,
    input  wire logic                 inval_all_i,
    input  wire logic [19:0]          inval_page_i,
    input  wire mtc_pkg::mtc_req_t    req_i,
    input  wire logic [3:0]           space_id_i,
    input  wire logic                 priv_cmp_i,
    input  wire logic                 page_prot_i,
    output mtc_pkg::mtc_rsp_t         rsp_o
);

    mtc_pkg::mtc_entry_t mem_q [ENTRIES];
    logic [ENTRIES-1:0]  vld_q;
    logic [ENTRIES-1:0]  match;
    mtc_pkg::mtc_rsp_t   rsp_d;

    // ------------------------------------------------------------------
    // Entry storage
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (load_i) begin
            mem_q[load_idx_i[$clog2(ENTRIES)-1:0]] <= load_entry_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            vld_q <= '0;
        end else begin
            for (int i = 0; i < ENTRIES; i++) begin
                if (inval_all_i || (inval_one_i && mem_q[i].epn == inval_page_i)) begin
                    vld_q[i] <= 1'b0;
                end
                if (load_i && load_idx_i == 5'(i)) begin
                    vld_q[i] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Match
    // ------------------------------------------------------------------
    for (genvar g = 0; g < ENTRIES; g++) begin : g_match
        logic tag_ok;
        logic priv_ok;
        logic sub_ok;
        assign tag_ok  = mem_q[g].common_space_page || mem_q[g].space_tag == space_id_i;
        assign priv_ok = !priv_cmp_i || mem_q[g].pp == `MTC_PP_BOTH
                       || (mem_q[g].pp == `MTC_PP_PRIV && req_i.priv)
                       || (mem_q[g].pp == `MTC_PP_PROB && !req_i.priv);
        assign sub_ok  = priv_cmp_i || (page_prot_i
                       ? mem_q[g].pp[2'h3 - req_i.page_sub[1:0]] : mem_q[g].pp[3]);
        assign match[g] = vld_q[g] && mem_q[g].valid && mem_q[g].epn == req_i.page_sub[21:2]
                        && tag_ok && priv_ok && sub_ok;
    end

    always_comb begin
        rsp_d       = '0;
        rsp_d.valid = req_i.valid;
        rsp_d.priv  = req_i.priv;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (match[i]) begin
                rsp_d.hit = req_i.valid;
                rsp_d.ci  = mem_q[i].cache_inhibit_attr;
                rsp_d.grp = mem_q[i].entry_group_select;
                rsp_d.pp  = mem_q[i].pp;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rsp_o <= '0;
        end else begin
            rsp_o <= rsp_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_inval_all;
        @(posedge mclk_i) disable iff (rst_i)
        (inval_all_i && !load_i) |=> (vld_q == '0);
    endproperty
    a_inval_all: assert property (p_inval_all) else $error("entries valid after flush");

endmodule : mtc_xlate
`default_nettype wire

// >>> logic/mtc_mmu_cfg.sv
// Purpose: Translation control registers, group protection and default attributes
// Assumes: Special-register moves arrive as select, read and write strobes on mclk_i
// Notes:   Lookup result is valid two cycles after the request
`include "mtc_defines.svh"
`default_nettype none
// Operation
// - Shared-page bit clear needs space tag equal to current space ID.
// - Descriptor bit 30 gives cache inhibit, bit 31 marks page valid.
// - Privilege compare mode 1: nibble 1000 privileged, 0100 problem, 1100 both.
// - Single and all-entry invalidation work whether translation is on or off.
// - Group mode bit selects standard keys at 0, domain manager at 1.
// - Page mode bit selects whole page at 0, 1K subpages at 1.
// - Instruction side uses inhibit default while its translation is off.
// - Data side uses inhibit and write-through defaults while translation off.
// - Keep-two bit makes pointer wrap modulo 6 instead of 8.
// - Entry pointer selects load target and decrements after each load.
// - Reserved control bits ignore writes and read zero.
// - Group-protection register has no reset value.
// - Domain mode: 00 none, 01 client checked, 10 reserved, 11 manager.
// - Standard mode: 00 privileged, 01 as is, 10 swapped, 11 problem.
// - Walk assist mode bit selects 1K subpage at 0, 4K page at 1.
// - Instruction control resets to zero; only bits set in MTC_ICTRL_MASK are read-writable.
// - Sixteen groups, chosen by the entry group select field.
module mtc_mmu_cfg #(
    parameter int ENTRIES = 8
) (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_i,
    input  wire logic [1:0]           spr_sel_i,
    input  wire logic                 spr_wr_i,
    input  wire logic                 spr_rd_i,
    input  wire logic [31:0]          spr_wdata_i,
    output logic [31:0]               spr_rdata_o,
    output logic                      spr_rvalid_o,
    input  wire logic                 instr_translate_on_i,
    input  wire logic                 data_translate_on_i,
    input  wire logic [3:0]           current_space_id_i,
    input  wire logic                 instr_load_i,
    input  wire mtc_pkg::mtc_entry_t  instr_load_entry_i,
    input  wire logic                 data_load_i,
    input  wire mtc_pkg::mtc_entry_t  data_load_entry_i,
    input  wire logic                 inval_one_i,
    input  wire logic                 inval_all_i,
    input  wire logic [19:0]          inval_page_i,
    input  wire mtc_pkg::mtc_req_t    instr_req_i,
    input  wire mtc_pkg::mtc_req_t    data_req_i,
    output mtc_pkg::mtc_res_t         instr_res_o,
    output mtc_pkg::mtc_res_t         data_res_o,
    output logic                      data_group_mode_o,
    output logic                      walk_assist_mode_o,
    output logic [4:0]                instr_entry_pointer_o,
    output logic [4:0]                data_entry_pointer_o
);

    logic [31:0]        ictrl_q;
    logic [31:0]        dctrl_q;
    logic [31:0]        iap_q;
    logic [4:0]         iptr;
    logic [4:0]         dptr;
    logic [31:0]        gp_shift;
    logic [1:0]         gp;
    logic               gp_deny;
    logic               gp_check;
    logic               eff_priv;
    logic               pp_ok;
    logic               instr_on_q;
    logic               data_on_q;
    logic               instr_on_qq;
    logic               data_on_qq;
    mtc_pkg::mtc_rsp_t  irsp;
    mtc_pkg::mtc_rsp_t  drsp;
    mtc_pkg::mtc_res_t  ires_d;
    mtc_pkg::mtc_res_t  dres_d;

    assign iptr = ictrl_q[`MTC_PTR_MSB:`MTC_PTR_LSB];
    assign dptr = dctrl_q[`MTC_PTR_MSB:`MTC_PTR_LSB];

    // ------------------------------------------------------------------
    // Pointer decrement
    // ------------------------------------------------------------------
    function automatic logic [4:0] next_ptr(input logic [4:0] p, input logic keep);
        logic [4:0] r;
        if (p == 5'h00) begin
            r = keep ? `MTC_WRAP_KEEP : `MTC_WRAP_FULL;
        end else begin
            r = p - 5'h01;
        end
        return r;
    endfunction : next_ptr

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ictrl_q <= `MTC_CTRL_RESET;
        end else if (spr_wr_i && spr_sel_i == `MTC_SEL_ICTRL) begin
            ictrl_q <= spr_wdata_i & `MTC_ICTRL_MASK;
        end else if (instr_load_i) begin
            ictrl_q[`MTC_PTR_MSB:`MTC_PTR_LSB] <= next_ptr(iptr, ictrl_q[`MTC_B_KEEP]);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            dctrl_q <= `MTC_CTRL_RESET;
        end else if (spr_wr_i && spr_sel_i == `MTC_SEL_DCTRL) begin
            dctrl_q <= spr_wdata_i & `MTC_DCTRL_MASK;
        end else if (data_load_i) begin
            dctrl_q[`MTC_PTR_MSB:`MTC_PTR_LSB] <= next_ptr(dptr, dctrl_q[`MTC_B_KEEP]);
        end
    end

    // Group register has no reset
    always_ff @(posedge mclk_i) begin
        if (spr_wr_i && spr_sel_i == `MTC_SEL_IAP) begin
            iap_q <= spr_wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            spr_rdata_o  <= '0;
            spr_rvalid_o <= 1'b0;
        end else begin
            spr_rvalid_o <= spr_rd_i;
            unique case (spr_sel_i)
                `MTC_SEL_ICTRL: spr_rdata_o <= spr_rd_i ? ictrl_q : 32'h00000000;
                `MTC_SEL_IAP:   spr_rdata_o <= spr_rd_i ? iap_q : 32'h00000000;
                `MTC_SEL_DCTRL: spr_rdata_o <= spr_rd_i ? dctrl_q : 32'h00000000;
                default:        spr_rdata_o <= 32'h00000000;
            endcase
        end
    end

    assign data_group_mode_o     = dctrl_q[`MTC_B_GPM];
    assign walk_assist_mode_o    = dctrl_q[`MTC_B_WALK_ASSIST_MODE];
    assign instr_entry_pointer_o = iptr;
    assign data_entry_pointer_o  = dptr;

    // ------------------------------------------------------------------
    // Entry stores
    // ------------------------------------------------------------------
    mtc_xlate #(
        .ENTRIES      (ENTRIES)
    ) u_instr (
        .mclk_i       (mclk_i),
        .rst_i        (rst_i),
        .load_i       (instr_load_i),
        .load_idx_i   (iptr),
        .load_entry_i (instr_load_entry_i),
        .inval_one_i  (inval_one_i),
        .inval_all_i  (inval_all_i),
        .inval_page_i (inval_page_i),
        .req_i        (instr_req_i),
        .space_id_i   (current_space_id_i),
        .priv_cmp_i   (ictrl_q[`MTC_B_PRIV_COMPARE_MODE]),
        .page_prot_i  (ictrl_q[`MTC_B_PPM]),
        .rsp_o        (irsp)
    );

    mtc_xlate #(
        .ENTRIES      (ENTRIES)
    ) u_data (
        .mclk_i       (mclk_i),
        .rst_i        (rst_i),
        .load_i       (data_load_i),
        .load_idx_i   (dptr),
        .load_entry_i (data_load_entry_i),
        .inval_one_i  (inval_one_i),
        .inval_all_i  (inval_all_i),
        .inval_page_i (inval_page_i),
        .req_i        (data_req_i),
        .space_id_i   (current_space_id_i),
        .priv_cmp_i   (dctrl_q[`MTC_B_PRIV_COMPARE_MODE]),
        .page_prot_i  (dctrl_q[`MTC_B_PPM]),
        .rsp_o        (drsp)
    );

    // ------------------------------------------------------------------
    // Instruction group protection
    // ------------------------------------------------------------------
    assign gp_shift = iap_q << {irsp.grp, 1'b0};
    assign gp       = gp_shift[31:30];

    always_comb begin
        gp_deny  = 1'b0;
        gp_check = 1'b1;
        eff_priv = irsp.priv;
        if (ictrl_q[`MTC_B_GPM]) begin
            unique case (gp)
                `MTC_GP_00: gp_deny  = 1'b1;
                `MTC_GP_01: gp_check = 1'b1;
                `MTC_GP_10: gp_deny  = 1'b1;
                `MTC_GP_11: gp_check = 1'b0;
            endcase
        end else begin
            unique case (gp)
                `MTC_GP_00: eff_priv = 1'b1;
                `MTC_GP_01: eff_priv = irsp.priv;
                `MTC_GP_10: eff_priv = !irsp.priv;
                `MTC_GP_11: eff_priv = 1'b0;
            endcase
        end
    end

    assign pp_ok = !ictrl_q[`MTC_B_PRIV_COMPARE_MODE] || irsp.pp == `MTC_PP_BOTH
                 || (irsp.pp == `MTC_PP_PRIV && eff_priv)
                 || (irsp.pp == `MTC_PP_PROB && !eff_priv);

    // ------------------------------------------------------------------
    // Result stage
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            instr_on_q  <= 1'b0;
            data_on_q   <= 1'b0;
            instr_on_qq <= 1'b0;
            data_on_qq  <= 1'b0;
        end else begin
            instr_on_q  <= instr_translate_on_i;
            data_on_q   <= data_translate_on_i;
            instr_on_qq <= instr_on_q;
            data_on_qq  <= data_on_q;
        end
    end

    always_comb begin
        ires_d       = '0;
        ires_d.valid = irsp.valid;
        if (instr_on_q) begin
            ires_d.hit   = irsp.hit;
            ires_d.ci    = irsp.ci;
            ires_d.allow = irsp.hit && !gp_deny && (!gp_check || pp_ok);
        end else begin
            ires_d.hit   = irsp.valid;
            ires_d.allow = irsp.valid;
            ires_d.ci    = ictrl_q[`MTC_B_INHIBIT_DEFAULT];
        end
    end

    always_comb begin
        dres_d       = '0;
        dres_d.valid = drsp.valid;
        if (data_on_q) begin
            dres_d.hit   = drsp.hit;
            dres_d.allow = drsp.hit;
            dres_d.ci    = drsp.ci;
        end else begin
            dres_d.hit   = drsp.valid;
            dres_d.allow = drsp.valid;
            dres_d.ci    = dctrl_q[`MTC_B_INHIBIT_DEFAULT];
            dres_d.wt    = dctrl_q[`MTC_B_WRITETHROUGH_DEFAULT];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            instr_res_o <= '0;
            data_res_o  <= '0;
        end else begin
            instr_res_o <= ires_d;
            data_res_o  <= dres_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_wrap_eight;
        @(posedge mclk_i) disable iff (rst_i)
        (instr_load_i && !spr_wr_i && iptr == 5'h00 && !ictrl_q[`MTC_B_KEEP])
            |=> (iptr == 5'h07);
    endproperty
    a_wrap_eight: assert property (p_wrap_eight) else $error("pointer wrap not 7");

    property p_wrap_six;
        @(posedge mclk_i) disable iff (rst_i)
        (data_load_i && !spr_wr_i && dptr == 5'h00 && dctrl_q[`MTC_B_KEEP])
            |=> (dptr == 5'h05);
    endproperty
    a_wrap_six: assert property (p_wrap_six) else $error("pointer wrap not 5");

    property p_ptr_dec;
        @(posedge mclk_i) disable iff (rst_i)
        (instr_load_i && !spr_wr_i && iptr != 5'h00) |=> (iptr == $past(iptr) - 5'h01);
    endproperty
    a_ptr_dec: assert property (p_ptr_dec) else $error("pointer not decremented");

    property p_rsvd_zero;
        @(posedge mclk_i) disable iff (rst_i)
        (spr_rd_i && spr_sel_i == `MTC_SEL_ICTRL)
            |=> spr_rvalid_o && ((spr_rdata_o & ~`MTC_ICTRL_MASK) == 32'h00000000);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read nonzero");

    property p_reset_zero;
        @(posedge mclk_i) rst_i |=> (ictrl_q == 32'h00000000);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("control not zero after reset");

    property p_idef;
        @(posedge mclk_i) disable iff (rst_i)
        (instr_req_i.valid && !instr_translate_on_i && !spr_wr_i) ##1 !spr_wr_i
            |=> (instr_res_o.ci == ictrl_q[`MTC_B_INHIBIT_DEFAULT]);
    endproperty
    a_idef: assert property (p_idef) else $error("instruction inhibit default not used");

    property p_ddef;
        @(posedge mclk_i) disable iff (rst_i)
        (data_req_i.valid && !data_translate_on_i && !spr_wr_i) ##1 !spr_wr_i
            |=> (data_res_o.wt == dctrl_q[`MTC_B_WRITETHROUGH_DEFAULT] && data_res_o.ci == dctrl_q[`MTC_B_INHIBIT_DEFAULT]);
    endproperty
    a_ddef: assert property (p_ddef) else $error("data defaults not used");

    property p_dom_none;
        @(posedge mclk_i) disable iff (rst_i)
        (instr_on_q && ictrl_q[`MTC_B_GPM] && gp == `MTC_GP_00 && !spr_wr_i)
            |=> (!instr_res_o.allow);
    endproperty
    a_dom_none: assert property (p_dom_none) else $error("no-access group allowed");

    property p_std_priv;
        @(posedge mclk_i) disable iff (rst_i)
        (!ictrl_q[`MTC_B_GPM] && gp == `MTC_GP_11) |-> !eff_priv;
    endproperty
    a_std_priv: assert property (p_std_priv) else $error("problem group seen privileged");

    c_wrap_six: cover property (@(posedge mclk_i) disable iff (rst_i)
        data_load_i && dptr == 5'h00 && dctrl_q[`MTC_B_KEEP]);
    c_instr_hit: cover property (@(posedge mclk_i) disable iff (rst_i)
        instr_res_o.valid && instr_res_o.hit && instr_on_qq);
    c_data_default: cover property (@(posedge mclk_i) disable iff (rst_i)
        data_res_o.valid && !data_on_qq);
    c_manager: cover property (@(posedge mclk_i) disable iff (rst_i)
        ictrl_q[`MTC_B_GPM] && gp == `MTC_GP_11 && irsp.hit);

endmodule : mtc_mmu_cfg
`default_nettype wire

// >>> tb/test_mtc_mmu_cfg.sv
// Purpose: Register, pointer and lookup checks of the translation config block
// Assumes: Fixed read and lookup latencies of the block
// Notes:   Inputs change 1 ns after the rising edge
`default_nettype none
module test_mtc_mmu_cfg;
    timeunit 1ns;
    timeprecision 1ps;
    logic                mclk_i;
    logic                rst_i;
    logic [1:0]          sel;
    logic                wr, rd, rvalid, itr, dtr, ild, dld, i1, ia, gm, wam;
    logic [31:0]         wdata, rdata;
    logic [3:0]          sid;
    logic [19:0]         ipage;
    logic [4:0]          iptr, dptr;
    mtc_pkg::mtc_entry_t ent;
    mtc_pkg::mtc_req_t   ireq, dreq;
    mtc_pkg::mtc_res_t   ires, dres;
    int                  fail_count;
    int                  comparisons;

    mtc_mmu_cfg #(.ENTRIES(8)) dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .spr_sel_i(sel), .spr_wr_i(wr), .spr_rd_i(rd),
        .spr_wdata_i(wdata), .spr_rdata_o(rdata), .spr_rvalid_o(rvalid),
        .instr_translate_on_i(itr), .data_translate_on_i(dtr), .current_space_id_i(sid),
        .instr_load_i(ild), .instr_load_entry_i(ent), .data_load_i(dld),
        .data_load_entry_i(ent), .inval_one_i(i1), .inval_all_i(ia), .inval_page_i(ipage),
        .instr_req_i(ireq), .data_req_i(dreq), .instr_res_o(ires), .data_res_o(dres),
        .data_group_mode_o(gm), .walk_assist_mode_o(wam),
        .instr_entry_pointer_o(iptr), .data_entry_pointer_o(dptr));

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    task automatic tick;
        @(posedge mclk_i);
        #1;
    endtask : tick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wreg(input logic [1:0] s, input logic [31:0] d);
        sel = s;
        wdata = d;
        wr = 1'b1;
        tick;
        wr = 1'b0;
        tick;
    endtask : wreg

    task automatic rreg(input logic [1:0] s, input logic [31:0] exp);
        sel = s;
        rd = 1'b1;
        tick;
        rd = 1'b0;
        chk(32'(rvalid), 32'h1);
        chk(rdata, exp);
        tick;
    endtask : rreg

    task automatic ld(input logic d);
        if (d) begin
            dld = 1'b1;
        end else begin
            ild = 1'b1;
        end
        tick;
        ild = 1'b0;
        dld = 1'b0;
        tick;
    endtask : ld

    task automatic look(input logic [19:0] pg, input logic pv = 1'b1);
        ireq = {1'b1, pg, 2'h0, pv};
        dreq = {1'b1, pg, 2'h0, pv};
        tick;
        ireq.valid = 1'b0;
        dreq.valid = 1'b0;
        tick;
    endtask : look

    task automatic summarize;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    initial begin
        {sel, wr, rd, wdata, itr, dtr, sid, ild, dld, i1, ia, ipage} = '0;
        ent = '0;
        ireq = '0;
        dreq = '0;
        fail_count = 0;
        comparisons = 0;
        rst_i = 1'b1;
        repeat (4) tick;
        rst_i = 1'b0;
        rreg(2'h0, 32'h0);
        rreg(2'h2, 32'h0);
        chk(32'(iptr), 32'h0);
        $display("Test reset values done");
        wreg(2'h0, 32'hffffffff);
        rreg(2'h0, 32'hea001f00);
        wreg(2'h2, 32'hffffffff);
        rreg(2'h2, 32'hfe001f00);
        chk(32'(gm), 32'h1);
        chk(32'(wam), 32'h1);
        wreg(2'h3, 32'hffffffff);
        rreg(2'h3, 32'h0);
        $display("Test register access done");
        wreg(2'h0, 32'h20000000);
        wreg(2'h2, 32'h10000000);
        wreg(2'h1, 32'h55555555);
        chk(32'(gm), 32'h0);
        chk(32'(wam), 32'h0);
        look(20'h12345);
        chk(32'(ires[4:1]), 32'hf);
        chk(32'(dres), 32'h1d);
        $display("Test default attributes done");
        wreg(2'h0, 32'h0);
        ld(1'b0);
        chk(32'(iptr), 32'h7);
        wreg(2'h0, 32'h08000000);
        ld(1'b0);
        chk(32'(iptr), 32'h5);
        wreg(2'h2, 32'h08000000);
        ld(1'b1);
        ld(1'b1);
        chk(32'(dptr), 32'h4);
        $display("Test entry pointer done");
        wreg(2'h0, 32'h0);
        itr = 1'b1;
        dtr = 1'b1;
        sid = 4'h3;
        ent = {20'h12345, 4'h3, 4'h0, 4'hf, 4'h3};
        ld(1'b0);
        ld(1'b1);
        look(20'h12345);
        chk(32'(ires[4:1]), 32'hf);
        chk(32'(dres), 32'h1e);
        sid = 4'h5;
        look(20'h12345);
        chk(32'(ires[4:3]), 32'h2);
        sid = 4'h3;
        ipage = 20'h12345;
        i1 = 1'b1;
        tick;
        i1 = 1'b0;
        tick;
        look(20'h12345);
        chk(32'(ires[4:3]), 32'h2);
        chk(32'(dres[4:3]), 32'h2);
        $display("Test lookup done");
        itr = 1'b0;
        wreg(2'h0, 32'h02000000);
        ent = {20'h12345, 4'h3, 4'h0, 4'h8, 4'h3};
        ld(1'b0);
        itr = 1'b1;
        look(20'h12345, 1'b0);
        chk(32'(ires[4:3]), 32'h2);
        look(20'h12345);
        chk(32'(ires[4:1]), 32'hf);
        itr = 1'b0;
        wreg(2'h1, 32'h80000000);
        itr = 1'b1;
        look(20'h12345);
        chk(32'(ires[4:2]), 32'h6);
        itr = 1'b0;
        wreg(2'h0, 32'h82000000);
        wreg(2'h1, 32'h3fffffff);
        itr = 1'b1;
        look(20'h12345);
        chk(32'(ires[4:2]), 32'h6);
        itr = 1'b0;
        wreg(2'h1, 32'hc0000000);
        itr = 1'b1;
        look(20'h12345);
        chk(32'(ires[4:1]), 32'hf);
        $display("Test group protection done");
        summarize;
    end
endmodule : test_mtc_mmu_cfg
`default_nettype wire
